// >>> core/ccs_clock_ctrl.sv
/*
  PLL and backup clock control: frequency select, reference supervision,
  lock filter, frequency monitor, missing-clock flag, driver disable and
  spread-spectrum modulation, with its two registers on the serial port.
  Assumes the register port is driven by the serial slave on core_clk_in,
  and that the analog PLL, oscillator and clock pins are outside.
*/
`timescale 1ns/1ns
module ccs_clock_ctrl
  import ccs_pkg::*;
#(
  parameter int unsigned MON_DIV = 2
)(
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [8:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [15:0] reg_rdata_out,
  input  wire logic        ref_clk_pin_in,
  input  wire logic        bak_clk_in,
  input  wire logic        pll_lock_raw_in,
  input  wire logic        sys_clk_div_in,
  input  wire logic        sys_clk_in,
  input  wire logic        supply_ok_in,
  output logic             pll_run_out,
  output logic      [5:0]  pll_mult_out,
  output logic      [1:0]  sys_post_div_out,
  output logic             sel_ext_ref_out,
  output logic             sel_bak_ref_out,
  output logic             cram_clk_out,
  output logic             dram_clk_out,
  output logic             mod_en_out,
  output logic signed [9:0] mod_trim_out,
  output logic             missing_out,
  output logic             drv_off_n_out
);

  // Scaling shift only serves 2 or 4
  if (MON_DIV != 2 && MON_DIV != 4) begin : g_bad_mon_div
    $error("MON_DIV must be 2 or 4");
  end


  localparam logic [2:0] MON_SHIFT = (MON_DIV == 4) ? 3'd2 : 3'd1;

  function automatic logic in_window(input logic [8:0] cnt,
                                     input logic [8:0] lo,
                                     input logic [8:0] hi);
    in_window = (cnt >= lo) && (cnt <= hi);
  endfunction

  // Two-stage synchronisers; stage 1 feeds only stage 2
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic       ref_s;
  logic       bak_s;
  logic       lock_s;
  logic       sdiv_s;
  logic       supply_s;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end else begin
      sync1_reg <= {supply_ok_in, sys_clk_div_in, pll_lock_raw_in, bak_clk_in, ref_clk_pin_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign {supply_s, sdiv_s, lock_s, bak_s, ref_s} = sync2_reg;

  // Edge detection on the synchronised copies
  logic ref_d_reg;
  logic bak_d_reg;
  logic sdiv_d_reg;
  logic ref_edge;
  logic bak_rise;
  logic sdiv_rise;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ref_d_reg  <= 1'b0;
      bak_d_reg  <= 1'b0;
      sdiv_d_reg <= 1'b0;
    end else begin
      ref_d_reg  <= ref_s;
      bak_d_reg  <= bak_s;
      sdiv_d_reg <= sdiv_s;
    end
  end

  assign ref_edge  = ref_s ^ ref_d_reg;
  assign bak_rise  = bak_s & ~bak_d_reg;
  assign sdiv_rise = sdiv_s & ~sdiv_d_reg;

  // Control registers
  logic cfg_low_freq_reg;
  logic mod_en_reg;
  logic drv_dis_reg;
  logic go_ext;
  logic wr_cfg;
  logic wr_stat;

  assign wr_cfg  = reg_wr_in && (reg_addr_in == REG_PLL_CFG);
  assign wr_stat = reg_wr_in && (reg_addr_in == REG_BAK_STAT);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_low_freq_reg <= CFG_LOW_FREQ_RST;
      mod_en_reg       <= CFG_MOD_EN_RST;
    end else if (wr_cfg) begin
      cfg_low_freq_reg <= reg_wdata_in[CFG_LOW_FREQ_BIT];
      mod_en_reg       <= reg_wdata_in[CFG_MOD_EN_BIT];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      drv_dis_reg <= STAT_DRV_DIS_RST;
    end else if (wr_stat) begin
      drv_dis_reg <= reg_wdata_in[STAT_DRV_DIS_BIT];
    end
  end

  assign go_ext = wr_cfg && reg_wdata_in[CFG_RETURN_BIT];

  // supplies gate the PLL; reset reaches it only by clearing the supply synchroniser
  assign pll_run_out = supply_s;

  assign pll_mult_out     = cfg_low_freq_reg ? PLL_MULT_LO : PLL_MULT_HI;
  assign sys_post_div_out = SYS_POST_DIV;

  assign cram_clk_out = ~sys_clk_in;
  assign dram_clk_out = ~sys_clk_in;

  // Reference presence: no edge for REF_LOSS_CYC means unsuitable
  logic [7:0] ref_idle_reg;
  logic       ref_lost;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ref_idle_reg <= 8'h00;
    end else if (ref_edge) begin
      ref_idle_reg <= 8'h00;
    end else if (ref_idle_reg != 8'(REF_LOSS_CYC)) begin
      ref_idle_reg <= ref_idle_reg + 8'h01;
    end
  end

  assign ref_lost = (ref_idle_reg == 8'(REF_LOSS_CYC));

  logic [9:0] lock_cnt_reg;
  logic       locked_reg;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lock_cnt_reg <= 10'h000;
      locked_reg   <= 1'b0;
    end else if (!lock_s || !supply_s) begin
      lock_cnt_reg <= 10'h000;
      locked_reg   <= 1'b0;
    end else if (lock_cnt_reg == 10'(LOCK_FILT_CYC - 1)) begin
      locked_reg   <= 1'b1;
    end else begin
      lock_cnt_reg <= lock_cnt_reg + 10'h001;
    end
  end

  // Reference switch
  logic on_backup;
  logic sel_ext;
  logic go_backup;
  logic lock_tmo_reg;
  logic freq_fault_reg;

  // fall back on a bad reference
  assign go_backup = sel_ext && (ref_lost || lock_tmo_reg || freq_fault_reg);

  ccs_ref_switch u_switch (
    .core_clk_in   (core_clk_in),
    .rst_n_in      (rst_n_in),
    .go_backup_in  (go_backup),
    .go_ext_in     (go_ext),
    .sel_ext_out   (sel_ext),
    .sel_bak_out   (sel_bak_ref_out),
    .on_backup_out (on_backup)
  );

  assign sel_ext_ref_out = sel_ext;

  logic [11:0] lock_wait_reg;
  logic        sel_ext_d_reg;
  logic        restart;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel_ext_d_reg <= 1'b0;
    end else begin
      sel_ext_d_reg <= sel_ext;
    end
  end

  assign restart = sel_ext & ~sel_ext_d_reg;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lock_wait_reg <= 12'h000;
      lock_tmo_reg  <= 1'b0;
    end else if (restart || locked_reg || !supply_s) begin
      lock_wait_reg <= 12'h000;
      lock_tmo_reg  <= 1'b0;
    end else if (lock_wait_reg == 12'(LOCK_MAX_CYC - 1)) begin
      lock_tmo_reg  <= 1'b1;
    end else begin
      lock_wait_reg <= lock_wait_reg + 12'h001;
    end
  end

  // Frequency monitor; a stopped backup oscillator freezes the verdict
  logic [2:0] win_reg;
  logic [7:0] sys_cnt_reg;
  logic [8:0] sys_scaled;
  logic       in_range;

  assign sys_scaled = {1'b0, sys_cnt_reg} << MON_SHIFT;

  assign in_range = cfg_low_freq_reg ? in_window(sys_scaled, LIM12_LO, LIM12_HI)
                                     : in_window(sys_scaled, LIM24_LO, LIM24_HI);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      win_reg <= 3'h0;
    end else if (bak_rise) begin
      win_reg <= (win_reg == 3'(MON_WIN_BAK - 1)) ? 3'h0 : win_reg + 3'h1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sys_cnt_reg <= 8'h00;
    end else if (bak_rise && win_reg == 3'(MON_WIN_BAK - 1)) begin
      sys_cnt_reg <= 8'h00;
    end else if (sdiv_rise && win_reg < 3'(MON_GATE_BAK) && sys_cnt_reg != 8'hFF) begin
      sys_cnt_reg <= sys_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      freq_fault_reg <= 1'b0;
    end else if (!locked_reg) begin
      freq_fault_reg <= 1'b0;
    end else if (bak_rise && win_reg == 3'(MON_WIN_BAK - 1)) begin
      freq_fault_reg <= ~in_range;
    end
  end

  logic missing_reg;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      missing_reg <= 1'b1;
    end else begin
      missing_reg <= ~locked_reg | freq_fault_reg;
    end
  end

  assign missing_out = missing_reg;

  assign drv_off_n_out = ~(missing_reg & drv_dis_reg);

  // triangle within 2.08 percent, one period every 1664 core clock cycles
  logic [1:0]        step_reg;
  logic              dir_up_reg;
  logic signed [9:0] trim_reg;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      step_reg   <= 2'h0;
      dir_up_reg <= 1'b1;
      trim_reg   <= 10'sh000;
    end else if (!mod_en_reg) begin
      step_reg   <= 2'h0;
      dir_up_reg <= 1'b1;
      trim_reg   <= 10'sh000;
    end else if (step_reg != 2'(MOD_STEP_CYC - 1)) begin
      step_reg <= step_reg + 2'h1;
    end else begin
      step_reg <= 2'h0;
      if (dir_up_reg) begin
        trim_reg   <= trim_reg + 10'sh001;
        dir_up_reg <= (trim_reg != 10'(MOD_DEV_MAX - 1));
      end else begin
        trim_reg   <= trim_reg - 10'sh001;
        dir_up_reg <= (trim_reg == -10'(MOD_DEV_MAX - 1));
      end
    end
  end

  assign mod_en_out   = mod_en_reg;
  assign mod_trim_out = trim_reg;

  // Register read, one cycle after the strobe
  ccs_status_t status;
  logic [15:0] rdata_reg;

  always_comb begin
    status.lock_timeout = lock_tmo_reg;
    status.freq_fault   = freq_fault_reg;
    status.pll_locked   = locked_reg;
    status.missing      = missing_reg;
    status.on_backup    = on_backup;
    status.drv_dis      = drv_dis_reg;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_reg <= 16'h0000;
    end else if (reg_rd_in) begin
      if (reg_addr_in == REG_PLL_CFG) begin
        rdata_reg <= {14'h0000, mod_en_reg, cfg_low_freq_reg};
      end else if (reg_addr_in == REG_BAK_STAT) begin
        rdata_reg <= {10'h000, status};
      end else begin
        rdata_reg <= 16'h0000;
      end
    end
  end

  assign reg_rdata_out = rdata_reg;

endmodule

// >>> core/ccs_pkg.sv
/*
  Constants, register map, field layout and state type for the PLL and
  backup clock control block.
  Assumes a 50 MHz core clock and a 9-bit word-addressed register port.
*/
package ccs_pkg;

  localparam int unsigned CLK_FREQ_HZ   = 50_000_000;
  localparam int unsigned CLK_PER_US    = CLK_FREQ_HZ / 1_000_000;

  // Register map (word offsets on the serial register port)
  localparam logic [8:0]  REG_PLL_CFG   = 9'h1C6;
  localparam logic [8:0]  REG_BAK_STAT  = 9'h1C7;

  // pll_configuration fields
  localparam int unsigned CFG_LOW_FREQ_BIT = 0;
  localparam int unsigned CFG_MOD_EN_BIT   = 1;
  localparam int unsigned CFG_RETURN_BIT   = 2;
  localparam logic        CFG_LOW_FREQ_RST = 1'b0;
  localparam logic        CFG_MOD_EN_RST   = 1'b1;

  // backup_clock_status: writable field
  localparam int unsigned STAT_DRV_DIS_BIT = 0;
  localparam logic        STAT_DRV_DIS_RST = 1'b0;

  // Timing, in the units printed, and the derived core clock counts
  localparam int unsigned LOCK_FILT_NS  = 10_000;
  localparam int unsigned LOCK_FILT_CYC = (LOCK_FILT_NS * CLK_PER_US + 999) / 1000;
  localparam int unsigned LOCK_MAX_NS   = 40_000;
  localparam int unsigned LOCK_MAX_CYC  = (LOCK_MAX_NS * CLK_PER_US) / 1000;
  localparam int unsigned REF_LOSS_NS   = 2_000;
  localparam int unsigned REF_LOSS_CYC  = (REF_LOSS_NS * CLK_PER_US) / 1000;
  localparam int unsigned MOD_FREQ_HZ   = 25_000;
  localparam int unsigned MOD_HALF_CYC  = CLK_FREQ_HZ / (2 * MOD_FREQ_HZ);

  // Modulation depth in units of 0.01 percent
  localparam int unsigned MOD_DEV_MAX   = 208;
  localparam int unsigned MOD_STEP_CYC  = MOD_HALF_CYC / (2 * MOD_DEV_MAX);

  // Clock synthesis ratios
  localparam logic [5:0]  PLL_MULT_HI   = 6'd48;
  localparam logic [5:0]  PLL_MULT_LO   = 6'd24;
  localparam logic [1:0]  SYS_POST_DIV  = 2'd2;

  // Frequency monitor, in backup oscillator cycles and system clock counts
  localparam int unsigned MON_GATE_BAK  = 6;
  localparam int unsigned MON_WIN_BAK   = 8;
  localparam logic [8:0]  LIM24_LO      = 9'd127;
  localparam logic [8:0]  LIM24_HI      = 9'd163;
  localparam logic [8:0]  LIM12_LO      = 9'd63;
  localparam logic [8:0]  LIM12_HI      = 9'd82;

  // Dead time between the two reference selects
  localparam int unsigned SW_GAP_CYC    = 4;

  typedef enum logic [1:0] {
    SW_EXT,
    SW_GAP_TO_BAK,
    SW_BAK,
    SW_GAP_TO_EXT
  } ccs_sw_state_t;

  // Read layout of backup_clock_status, bit 0 upward from the last member
  typedef struct packed {
    logic lock_timeout;
    logic freq_fault;
    logic pll_locked;
    logic missing;
    logic on_backup;
    logic drv_dis;
  } ccs_status_t;

endpackage

// >>> core/ccs_ref_switch.sv
/*
  Reference source switch: external clock pin or backup oscillator,
  with a break-before-make gap so the PLL input never sees a runt pulse.
  Assumes requests come from logic on the core clock.
*/
`timescale 1ns/1ns
module ccs_ref_switch
  import ccs_pkg::*;
(
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  input  wire logic go_backup_in,
  input  wire logic go_ext_in,
  output logic      sel_ext_out,
  output logic      sel_bak_out,
  output logic      on_backup_out
);

  ccs_sw_state_t state_reg;
  ccs_sw_state_t state_next;
  logic [2:0]    gap_reg;
  logic          sel_ext_reg;
  logic          sel_bak_reg;

  localparam logic [2:0] GAP_LAST = 3'(SW_GAP_CYC - 1);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SW_EXT:        if (go_backup_in) state_next = SW_GAP_TO_BAK;
      SW_GAP_TO_BAK: if (gap_reg == GAP_LAST) state_next = SW_BAK;
      SW_BAK:        if (go_ext_in) state_next = SW_GAP_TO_EXT;
      SW_GAP_TO_EXT: if (gap_reg == GAP_LAST) state_next = SW_EXT;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= SW_EXT;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap_reg <= 3'h0;
    end else if (state_next != state_reg) begin
      gap_reg <= 3'h0;
    end else begin
      gap_reg <= gap_reg + 3'h1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel_ext_reg <= 1'b1;
      sel_bak_reg <= 1'b0;
    end else begin
      sel_ext_reg <= (state_next == SW_EXT);
      sel_bak_reg <= (state_next == SW_BAK);
    end
  end

  assign sel_ext_out   = sel_ext_reg;
  assign sel_bak_out   = sel_bak_reg;
  assign on_backup_out = (state_reg != SW_EXT);

endmodule

// >>> verification/ccs_clock_ctrl_monitor.sv
/*
  Checker for the clock control block, bound to its top module.
  Assumes one core clock domain and the constants of the package.
*/
`timescale 1ns/1ns
module ccs_clock_ctrl_monitor
  import ccs_pkg::*;
#(
  parameter int unsigned MON_DIV = 2
)(
  input wire logic        core_clk_in,
  input wire logic        rst_n_in,
  input wire logic [8:0]  reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        pll_lock_raw_in,
  input wire logic        sys_clk_in,
  input wire logic [5:0]  pll_mult_out,
  input wire logic        sel_ext_ref_out,
  input wire logic        sel_bak_ref_out,
  input wire logic        cram_clk_out,
  input wire logic        dram_clk_out,
  input wire logic        mod_en_out,
  input wire logic        missing_out,
  input wire logic        drv_off_n_out
);
  logic       wr_cfg;
  logic       cfg_lo;
  logic       cfg_mod;
  logic       ret_wr;
  logic       wr_dis;
  logic [9:0] lock_cnt_reg;

  assign wr_cfg  = reg_wr_in && (reg_addr_in == REG_PLL_CFG);
  assign cfg_lo  = reg_wdata_in[CFG_LOW_FREQ_BIT];
  assign cfg_mod = reg_wdata_in[CFG_MOD_EN_BIT];
  assign ret_wr  = wr_cfg && reg_wdata_in[CFG_RETURN_BIT];
  assign wr_dis  = reg_wr_in && (reg_addr_in == REG_BAK_STAT) && reg_wdata_in[STAT_DRV_DIS_BIT];

  // Run length of raw lock, saturating
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lock_cnt_reg <= 10'h000;
    end else if (!pll_lock_raw_in) begin
      lock_cnt_reg <= 10'h000;
    end else if (lock_cnt_reg != 10'h3FF) begin
      lock_cnt_reg <= lock_cnt_reg + 10'h001;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_mult_sel;
    wr_cfg |=> pll_mult_out == ($past(cfg_lo) ? PLL_MULT_LO : PLL_MULT_HI);
  endproperty
  a_mult_sel: assert property (p_mult_sel)
    else $error("multiplier does not follow frequency select");
  property p_mod_en;
    wr_cfg |=> mod_en_out == $past(cfg_mod);
  endproperty
  a_mod_en: assert property (p_mod_en)
    else $error("modulation enable does not follow write");
  property p_ram_inv;
    (cram_clk_out == !sys_clk_in) && (dram_clk_out == !sys_clk_in);
  endproperty
  a_ram_inv: assert property (p_ram_inv)
    else $error("memory clocks are not inverted system clock");
  property p_gap;
    $fell(sel_ext_ref_out) |-> !sel_bak_ref_out [*4] ##1 sel_bak_ref_out;
  endproperty
  a_gap: assert property (p_gap)
    else $error("backup select not raised after four cycle gap");
  property p_ret_only;
    $fell(sel_bak_ref_out) |-> $past(ret_wr) || $past(ret_wr, 2);
  endproperty
  a_ret_only: assert property (p_ret_only)
    else $error("left backup without a return write");
  property p_dis_on;
    wr_dis ##1 missing_out |-> !drv_off_n_out;
  endproperty
  a_dis_on: assert property (p_dis_on)
    else $error("drivers not off during missing clock");
  property p_unlock;
    !pll_lock_raw_in [*6] |=> missing_out;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("missing flag low while unlocked");
  property p_filter;
    $fell(missing_out) |-> ({22'h0, lock_cnt_reg} >= LOCK_FILT_CYC);
  endproperty
  a_filter: assert property (p_filter)
    else $error("missing flag cleared before lock filter time");
  property p_excl;
    !(sel_ext_ref_out && sel_bak_ref_out);
  endproperty
  a_excl: assert property (p_excl)
    else $error("both reference selects high");
endmodule

// >>> verification/ccs_clock_ctrl_tb.sv
/*
  Self-checking bench for the clock control block with its far side model.
  Assumes a 50 MHz core clock and register reads answered one cycle later.
*/
`timescale 1ns/1ns
module ccs_clock_ctrl_tb
  import ccs_pkg::*;
;
  localparam int unsigned MON_DIV = 2;
  logic        core_clk_in = 1'b0;
  logic        rst_n_in;
  logic [8:0]  reg_addr_in;
  logic [15:0] reg_wdata_in;
  logic        reg_wr_in;
  logic        reg_rd_in;
  logic [15:0] reg_rdata_out;
  logic        ref_clk;
  logic        bak_clk;
  logic        lock_raw;
  logic        sys_div;
  logic        supply_ok;
  logic        ref_on;
  logic        slow;
  logic        pll_run_out;
  logic [5:0]  pll_mult_out;
  logic [1:0]  sys_post_div_out;
  logic        sel_ext_ref_out;
  logic        sel_bak_ref_out;
  logic        cram_clk_out;
  logic        dram_clk_out;
  logic        mod_en_out;
  logic signed [9:0] mod_trim_out;
  logic        missing_out;
  logic        drv_off_n_out;
  logic        rd_seen = 1'b0;
  logic [15:0] exp_q[$];
  logic [15:0] mask_q[$];
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          seed = 61;

  always #10 core_clk_in = ~core_clk_in;

  ccs_clock_ctrl #(.MON_DIV(MON_DIV)) i_dut (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .ref_clk_pin_in(ref_clk), .bak_clk_in(bak_clk),
    .pll_lock_raw_in(lock_raw), .sys_clk_div_in(sys_div), .sys_clk_in(sys_div),
    .supply_ok_in(supply_ok), .pll_run_out(pll_run_out), .pll_mult_out(pll_mult_out),
    .sys_post_div_out(sys_post_div_out), .sel_ext_ref_out(sel_ext_ref_out),
    .sel_bak_ref_out(sel_bak_ref_out), .cram_clk_out(cram_clk_out),
    .dram_clk_out(dram_clk_out), .mod_en_out(mod_en_out), .mod_trim_out(mod_trim_out),
    .missing_out(missing_out), .drv_off_n_out(drv_off_n_out));

  ccs_far_side_model #(.MON_DIV(MON_DIV)) i_far (
    .sel_ext_in(sel_ext_ref_out), .sel_bak_in(sel_bak_ref_out), .ref_on_in(ref_on),
    .slow_in(slow), .supply_ok_in(supply_ok), .mult_in(pll_mult_out),
    .ref_clk_out(ref_clk), .bak_clk_out(bak_clk), .lock_raw_out(lock_raw),
    .sys_div_out(sys_div));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [8:0] a, input logic [15:0] d);
    @(negedge core_clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge core_clk_in);
    reg_wr_in = 1'b0;
  endtask

  task automatic reg_read(input logic [8:0] a, input logic [15:0] e, input logic [15:0] m);
    @(negedge core_clk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    exp_q.push_back(e);
    mask_q.push_back(m);
    @(negedge core_clk_in);
    reg_rd_in = 1'b0;
  endtask

  // Bounded wait on missing (0), external select (1) or backup select (2)
  task automatic wait_for(input int which, input logic val, input int limit);
    logic cur;
    for (int i = 0; i < limit; i++) begin
      cur = (which == 0) ? missing_out : (which == 1) ? sel_ext_ref_out : sel_bak_ref_out;
      if (cur === val) break;
      @(negedge core_clk_in);
    end
    check((which == 0) ? "missing" : (which == 1) ? "sel_ext" : "sel_bak", cur, val);
  endtask

  // Read results are compared one cycle after the strobe edge
  always @(posedge core_clk_in) rd_seen <= reg_rd_in && rst_n_in;
  always @(negedge core_clk_in) begin
    if (rd_seen && exp_q.size() == 0) check("read order", 16'h0001, 16'h0000);
    else if (rd_seen) check("rdata", reg_rdata_out & mask_q.pop_front(), exp_q.pop_front());
  end

  initial begin
    // About three and a half times the expected run of some 8,500 cycles
    #600_000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    logic [31:0] rnd;
    int t;
    int trim_max;
    rst_n_in = 1'b0;
    reg_addr_in = 9'h000;
    reg_wdata_in = 16'h0000;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    supply_ok = 1'b1;
    ref_on = 1'b1;
    slow = 1'b0;
    repeat (8) @(negedge core_clk_in);
    rst_n_in = 1'b1;
    check("mult", pll_mult_out, PLL_MULT_HI);
    check("mod_en", mod_en_out, 1'b1);
    reg_read(REG_PLL_CFG, 16'h0002, 16'h0007);
    reg_read(REG_BAK_STAT, 16'h0004, 16'h0007);
    check("pll_run", pll_run_out, 1'b1);
    rnd = $random(seed);
    reg_write({1'b0, rnd[7:0]}, rnd[31:16]);
    reg_read({1'b0, rnd[15:8]}, 16'h0000, 16'hFFFF);
    reg_read(REG_PLL_CFG, 16'h0002, 16'h0007);
    $display("test reset done");
    for (int i = 1; i >= 0; i--) begin
      reg_write(REG_PLL_CFG, {14'h0, 1'b1, i[0]});
      check("mult", pll_mult_out, (i == 1) ? PLL_MULT_LO : PLL_MULT_HI);
      check("post_div", sys_post_div_out, SYS_POST_DIV);
      reg_read(REG_PLL_CFG, {14'h0, 1'b1, i[0]}, 16'h0003);
    end
    trim_max = 0;
    repeat (2000) begin
      @(negedge core_clk_in);
      t = mod_trim_out;
      if (t < 0) t = -t;
      if (t > trim_max) trim_max = t;
    end
    check("trim peak", 16'(trim_max), 16'(MOD_DEV_MAX));
    reg_write(REG_PLL_CFG, 16'h0000);
    check("mod_en", mod_en_out, 1'b0);
    reg_read(REG_PLL_CFG, 16'h0000, 16'h0003);
    reg_write(REG_PLL_CFG, 16'h0002);
    $display("test select done");
    wait_for(0, 1'b0, 2000);
    reg_read(REG_BAK_STAT, 16'h0008, 16'h000E);
    reg_write(REG_BAK_STAT, 16'h0001);
    check("drv_off_n", drv_off_n_out, 1'b1);
    ref_on = 1'b0;
    wait_for(0, 1'b1, 200);
    check("drv_off_n", drv_off_n_out, 1'b0);
    reg_write(REG_PLL_CFG, 16'h0003);
    wait_for(1, 1'b0, 300);
    wait_for(2, 1'b1, 10);
    reg_read(REG_BAK_STAT, 16'h0003, 16'h0003);
    wait_for(0, 1'b0, 2000);
    check("drv_off_n", drv_off_n_out, 1'b1);
    $display("test fallback done");
    ref_on = 1'b1;
    repeat (3000) @(negedge core_clk_in);
    check("sel_bak", sel_bak_ref_out, 1'b1);
    reg_write(REG_PLL_CFG, 16'h0007);
    wait_for(1, 1'b1, 20);
    check("sel_bak", sel_bak_ref_out, 1'b0);
    wait_for(0, 1'b0, 2000);
    repeat (1000) @(negedge core_clk_in);
    check("sel_ext", sel_ext_ref_out, 1'b1);
    slow = 1'b1;
    wait_for(1, 1'b0, 1000);
    $display("test return done");
    // Second reset with the 12 MHz setting active
    rst_n_in = 1'b0;
    repeat (2) @(negedge core_clk_in);
    rst_n_in = 1'b1;
    check("mult", pll_mult_out, PLL_MULT_HI);
    check("mod_en", mod_en_out, 1'b1);
    reg_read(REG_PLL_CFG, 16'h0002, 16'h0007);
    supply_ok = 1'b0;
    repeat (4) @(negedge core_clk_in);
    check("pll_run", pll_run_out, 1'b0);
    wait_for(0, 1'b1, 10);
    $display("test reset again done");
    complete_run();
  end
endmodule

bind ccs_clock_ctrl ccs_clock_ctrl_monitor #(.MON_DIV(MON_DIV)) i_mon (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .pll_lock_raw_in(pll_lock_raw_in),
  .sys_clk_in(sys_clk_in), .pll_mult_out(pll_mult_out), .sel_ext_ref_out(sel_ext_ref_out),
  .sel_bak_ref_out(sel_bak_ref_out), .cram_clk_out(cram_clk_out),
  .dram_clk_out(dram_clk_out), .mod_en_out(mod_en_out), .missing_out(missing_out),
  .drv_off_n_out(drv_off_n_out));

// >>> verification/ccs_far_side_model.sv
/*
  Behavioural PLL, reference pin and backup oscillator around the block.
  Assumes the block's selects and multiplier; slow_in mimics a bad PLL.
*/
`timescale 1ns/1ns
module ccs_far_side_model
  import ccs_pkg::*;
#(
  parameter int unsigned MON_DIV = 2
)(
  input  wire logic       sel_ext_in,
  input  wire logic       sel_bak_in,
  input  wire logic       ref_on_in,
  input  wire logic       slow_in,
  input  wire logic       supply_ok_in,
  input  wire logic [5:0] mult_in,
  output logic            ref_clk_out,
  output logic            bak_clk_out,
  output logic            lock_raw_out,
  output logic            sys_div_out
);
  logic [4:0] lock_cnt_reg;
  logic [5:0] mult_reg;
  logic       present;
  int         half;

  initial begin
    ref_clk_out  = 1'b0;
    bak_clk_out  = 1'b0;
    sys_div_out  = 1'b0;
    lock_cnt_reg = 5'h00;
    mult_reg     = PLL_MULT_HI;
  end
  always #500 bak_clk_out = ~bak_clk_out;
  // Reference stands still while switched off
  always begin
    #500;
    ref_clk_out = ref_on_in ? ~ref_clk_out : 1'b0;
  end
  assign present = supply_ok_in && (sel_bak_in || (sel_ext_in && ref_on_in));
  // lock after 15 us of input, no reset involved
  always @(posedge bak_clk_out) begin
    if (!present || (mult_in != mult_reg)) lock_cnt_reg <= 5'h00;
    else if (lock_cnt_reg != 5'h0F) lock_cnt_reg <= lock_cnt_reg + 5'h01;
    mult_reg <= mult_in;
  end
  assign lock_raw_out = present && (lock_cnt_reg == 5'h0F);
  assign half = ((mult_in == PLL_MULT_HI) ? 21 : 42) * MON_DIV * (slow_in ? 2 : 1);
  always begin
    if (lock_raw_out) begin
      #(half) sys_div_out = ~sys_div_out;
    end else begin
      sys_div_out = 1'b0;
      #10;
    end
  end
endmodule
